// ### pkg/hid_filter_regs.vh
// How it works
// - no forwarding unless self-test passed
// - failed self-test enters failure state
// - firmware integrity check before data flow
// - lamp blinks while in failure state
// - stays disabled until self-test passes
// - every reset reruns the self-test
// - keyboard accepted only after type check
// - mouse accepted only after type check
// - key codes framed and merged with mouse
// - only hid class devices accepted
// - re-enumeration as any type rejects
// - merged stream leaves one way only
// - host side sees composite keyboard/mouse
// - host lock updates never reach keyboard
// - keep at most four recent key codes
// - exactly one host computer port
// - no firmware access path on ports
// - rejection shown on indicator output
`ifndef HID_FILTER_REGS_VH
`define HID_FILTER_REGS_VH
`define HID_CLASS_CODE     8'h03
`define ROM_WORDS          256
`define ROM_AW             8
`define DIGEST_RESET       32'h0000_0000
`define CLK_HZ             25000000
`define BLINK_MS           250
`define BLINK_CYCLES       ((`CLK_HZ / 1000) * `BLINK_MS)
`define SRC_KEY            1'b0
`define SRC_PTR            1'b1
`define KEY_HIST           4
`define FIFO_DEPTH         8
`define FIFO_AW            3
`define WORD_W             9
`endif

// ### tb/diode_sink.sv
`timescale 1ns/1ps
module diode_sink (
	input  wire       core_clk_i,
	input  wire       srst_i,
	input  wire       stall_i,
	input  wire       valid_i,
	input  wire [8:0] data_i,
	output wire       ready_o,
	output reg  [8:0] last_o,
	output reg  [7:0] count_o
);
	// host side may hold off; words only taken on ready
	assign ready_o = !stall_i;
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			count_o <= 8'h00;
			last_o  <= 9'h000;
		end else if (valid_i && ready_o) begin
			count_o <= count_o + 8'h01;
			last_o  <= data_i;
		end
	end
endmodule // diode_sink

// ### tb/hid_filter_gate_control_test.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run = tests_run + 1; if ((s) !== (e)) begin $display("CHECK FAILED %s exp %h got %h", n, e, s); miscompares = miscompares + 1; end end
module hid_filter_gate_control_test;
	reg        core_clk_i = 1'b0, srst_i = 1'b1, stall = 1'b0, lock_v = 1'b0;
	reg        key_attach_i = 1'b0, key_enum_i = 1'b0, key_valid_i = 1'b0;
	reg        ptr_attach_i = 1'b0, ptr_enum_i = 1'b0, ptr_valid_i = 1'b0;
	reg  [7:0] key_class_i = 8'h00, key_code_i = 8'h00, ptr_class_i = 8'h00, ptr_data_i = 8'h00;
	reg  [2:0] lock = 3'h0;
	reg [31:0] expd = 32'h0;
	wire [7:0] rom_addr_o, cnt;
	wire [31:0] rom_data_i = {rom_addr_o, ~rom_addr_o, 16'h5a3c};
	wire       diode_valid_o, diode_ready_i, fail_led_o, reject_led_o, flow_enable_o;
	wire [8:0] diode_data_o, last;
	wire [31:0] key_history_o;
	integer    miscompares = 0, tests_run = 0, cycles = 0;
	initial forever #20 core_clk_i = ~core_clk_i;
	hid_filter_gate_control DUT (.core_clk_i(core_clk_i), .srst_i(srst_i), .rom_addr_o(rom_addr_o),
		.rom_data_i(rom_data_i), .rom_expected_i(expd), .key_attach_i(key_attach_i),
		.key_enum_i(key_enum_i), .key_class_i(key_class_i), .key_valid_i(key_valid_i),
		.key_code_i(key_code_i), .ptr_attach_i(ptr_attach_i), .ptr_enum_i(ptr_enum_i),
		.ptr_class_i(ptr_class_i), .ptr_valid_i(ptr_valid_i), .ptr_data_i(ptr_data_i),
		.host_lock_valid_i(lock_v), .host_lock_i(lock), .diode_valid_o(diode_valid_o),
		.diode_ready_i(diode_ready_i), .diode_data_o(diode_data_o), .fail_led_o(fail_led_o),
		.reject_led_o(reject_led_o), .flow_enable_o(flow_enable_o), .key_history_o(key_history_o));
	diode_sink u_sink (.core_clk_i(core_clk_i), .srst_i(srst_i), .stall_i(stall),
		.valid_i(diode_valid_o), .data_i(diode_data_o), .ready_o(diode_ready_i),
		.last_o(last), .count_o(cnt));
	function [31:0] dig(input integer unused);
		integer i;
		reg [31:0] d;
		reg [7:0] a;
		begin
			d = 32'h0;
			for (i = 0; i < 256; i = i + 1) begin
				a = i;
				d = {d[30:0], d[31]} ^ {a, ~a, 16'h5a3c};
			end
			dig = d;
		end
	endfunction
	task cyc(input integer n);
		begin
			repeat (n) @(posedge core_clk_i);
			#1;
		end
	endtask
	task boot(input [31:0] e);
		begin
			expd = e;
			srst_i = 1'b1;
			key_attach_i = 1'b0;
			ptr_attach_i = 1'b0;
			cyc(8);
			srst_i = 1'b0;
			cyc(260);
		end
	endtask
	task enum_dev(input s, input [7:0] c);
		begin
			key_attach_i = key_attach_i | !s;
			ptr_attach_i = ptr_attach_i | s;
			key_class_i = c;
			ptr_class_i = c;
			key_enum_i = !s;
			ptr_enum_i = s;
			cyc(1);
			key_enum_i = 1'b0;
			ptr_enum_i = 1'b0;
			cyc(2);
		end
	endtask
	// stalls the sink first so the stream must hold its word
	task send(input s, input [7:0] v);
		reg [7:0] n0;
		begin
			n0 = cnt;
			stall = 1'b1;
			key_code_i = v;
			ptr_data_i = v;
			key_valid_i = !s;
			ptr_valid_i = s;
			cyc(1);
			key_valid_i = 1'b0;
			ptr_valid_i = 1'b0;
			cyc(3);
			stall = 1'b0;
			repeat (20) if (cnt === n0) cyc(1);
		end
	endtask
	task t_fail;
		begin
			boot(dig(0) ^ 32'h1);
			enum_dev(1'b0, 8'h03);
			send(1'b0, 8'h04);
			`CHK("flow", 1'b0, flow_enable_o)
			`CHK("count", 8'h00, cnt)
			`CHK("lamp", 1'b0, fail_led_o)
		end
	endtask
	task t_run;
		integer i;
		begin
			boot(dig(0));
			`CHK("flow", 1'b1, flow_enable_o)
			enum_dev(1'b0, 8'h03);
			for (i = 0; i < 5; i = i + 1) send(1'b0, 8'h1e + i);
			`CHK("key word", 9'h022, last)
			`CHK("history", 32'h1f202122, key_history_o)
			enum_dev(1'b1, 8'h03);
			send(1'b1, 8'h81);
			`CHK("ptr word", 9'h181, last)
			`CHK("reject", 1'b0, reject_led_o)
			key_code_i = 8'h2c;
			ptr_data_i = 8'h2d;
			key_valid_i = 1'b1;
			ptr_valid_i = 1'b1;
			cyc(1);
			key_valid_i = 1'b0;
			ptr_valid_i = 1'b0;
			cyc(4);
			`CHK("pair word", 9'h02c, last)
			`CHK("pair count", 8'h07, cnt)
			lock_v = 1'b1;
			lock = 3'h7;
			cyc(4);
			`CHK("lock", 8'h07, cnt)
			enum_dev(1'b1, 8'h03);
			send(1'b1, 8'h55);
			`CHK("reenum", 1'b1, reject_led_o)
			`CHK("dropped", 8'h07, cnt)
		end
	endtask
	task t_class;
		begin
			boot(dig(0));
			enum_dev(1'b0, 8'h08);
			send(1'b0, 8'h33);
			`CHK("class", 8'h00, cnt)
			`CHK("reject", 1'b1, reject_led_o)
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", tests_run, miscompares);
			if (miscompares == 0 && tests_run > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// ceiling covers three boots and short traffic
	always @(posedge core_clk_i) begin
		cycles = cycles + 1;
		if (cycles == 5000) begin
			miscompares = miscompares + 1;
			tally_and_finish;
		end
	end
	initial begin
		t_fail;
		t_run;
		t_class;
		tally_and_finish;
	end
endmodule // hid_filter_gate_control_test

// ### tb/hid_gate_checker.sv
`timescale 1ns/1ps
module hid_gate_checker (
	// clock and reset
	input wire        core_clk_i,
	input wire        srst_i,
	// watched inputs
	input wire        key_attach_i,
	input wire        ptr_attach_i,
	input wire        key_valid_i,
	input wire        diode_ready_i,
	// watched outputs
	input wire        diode_valid_o,
	input wire [8:0]  diode_data_o,
	input wire        fail_led_o,
	input wire        reject_led_o,
	input wire        flow_enable_o,
	input wire [31:0] key_history_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	gated_stream_a: assert property (!flow_enable_o |-> !diode_valid_o)
		else $error("stream word while gated");
	fail_no_run_a: assert property (fail_led_o |-> !flow_enable_o)
		else $error("running in failure state");
	check_first_a: assert property ($fell(srst_i) |-> !flow_enable_o [*8])
		else $error("flow before check done");
	run_sticky_a: assert property (flow_enable_o |=> flow_enable_o)
		else $error("run state lost");
	reset_gates_a: assert property (disable iff (1'b0) srst_i |=> !flow_enable_o && !diode_valid_o)
		else $error("reset left flow open");
	stream_hold_a: assert property (diode_valid_o && !diode_ready_i |=> diode_valid_o && $stable(diode_data_o))
		else $error("stream word dropped");
	reject_hold_a: assert property (reject_led_o && key_attach_i && ptr_attach_i |=> reject_led_o)
		else $error("reject indication lost");
	history_idle_a: assert property (!$past(key_valid_i) |=> $stable(key_history_o))
		else $error("history moved without key");
endmodule // hid_gate_checker
bind hid_filter_gate_control hid_gate_checker u_chk (.core_clk_i(core_clk_i), .srst_i(srst_i),
	.key_attach_i(key_attach_i), .ptr_attach_i(ptr_attach_i), .key_valid_i(key_valid_i),
	.diode_ready_i(diode_ready_i), .diode_valid_o(diode_valid_o), .diode_data_o(diode_data_o),
	.fail_led_o(fail_led_o), .reject_led_o(reject_led_o), .flow_enable_o(flow_enable_o),
	.key_history_o(key_history_o));

// ### verilog/hid_filter_gate_control.v
`timescale 1ns/1ps
`include "hid_filter_regs.vh"

module stream_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// clock and reset
	input  wire             core_clk_i,
	input  wire             srst_i,
	// fill side
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	// drain side
	output wire             out_valid_o,
	input  wire             out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            full;
	wire            empty;
	wire            do_wr;
	wire            do_rd;

	assign full        = (count == DEPTH[AW:0]);
	assign empty       = (count == {(AW+1){1'b0}});
	assign in_ready_o  = ~full;
	assign out_valid_o = ~empty;
	assign out_data_o  = mem[rd_ptr];
	assign do_wr       = in_valid_i & in_ready_o;
	assign do_rd       = out_valid_o & out_ready_i;

	// storage has no reset; only words below count are ever read
	always @(posedge core_clk_i) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always @(posedge core_clk_i) begin
		if (srst_i) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
		end else begin
			if (do_wr) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	always @(posedge core_clk_i) begin
		if (srst_i) begin
			count <= {(AW+1){1'b0}};
		end else if (do_wr && !do_rd) begin
			count <= count + 1'b1;
		end else if (do_rd && !do_wr) begin
			count <= count - 1'b1;
		end
	end
endmodule // stream_fifo

module hid_filter_gate_control (
	// clock and reset
	input  wire        core_clk_i,
	input  wire        srst_i,
	// firmware rom read port, internal only
	output reg  [7:0]  rom_addr_o,
	input  wire [31:0] rom_data_i,
	input  wire [31:0] rom_expected_i,
	// keyboard port enumeration
	input  wire        key_attach_i,
	input  wire        key_enum_i,
	input  wire [7:0]  key_class_i,
	input  wire        key_valid_i,
	input  wire [7:0]  key_code_i,
	// pointer port enumeration
	input  wire        ptr_attach_i,
	input  wire        ptr_enum_i,
	input  wire [7:0]  ptr_class_i,
	input  wire        ptr_valid_i,
	input  wire [7:0]  ptr_data_i,
	// host lock indicator updates, absorbed here
	input  wire        host_lock_valid_i,
	input  wire [2:0]  host_lock_i,
	// one-way stream to host side emulator
	output reg         diode_valid_o,
	input  wire        diode_ready_i,
	output reg  [8:0]  diode_data_o,
	// indicators
	output reg         fail_led_o,
	output reg         reject_led_o,
	output reg         flow_enable_o,
	output reg  [31:0] key_history_o
);
	localparam ST_CHECK = 3'b001;
	localparam ST_RUN   = 3'b010;
	localparam ST_FAIL  = 3'b100;
	localparam CH_KEY   = 0;
	localparam CH_PTR   = 1;

	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg  [31:0] digest;
	reg  [23:0] blink_cnt;
	reg         blink_tick;
	reg  [1:0]  port_ok;
	reg  [1:0]  port_rej;
	reg  [7:0]  hist [0:`KEY_HIST-1];
	reg         turn;
	wire        flow;
	wire        walk_last;
	wire        unused_lock;
	wire [1:0]  port_attach;
	wire [1:0]  port_enum;
	wire [15:0] port_class;
	wire [1:0]  port_valid;
	wire [1:0]  port_hid;
	wire        key_push;
	wire        ptr_push;
	wire        fifo_in_valid;
	wire        fifo_in_ready;
	wire [8:0]  fifo_in_data;
	wire        fifo_out_valid;
	wire        fifo_out_ready;
	wire [8:0]  fifo_out_data;
	wire        take;
	wire        hist_shift;
	wire [31:0] next_digest;
	genvar      gi;

	// lock updates end here; nothing leads back to the keyboard
	assign unused_lock = host_lock_valid_i & (|host_lock_i);
	assign next_digest = {digest[30:0], digest[31]} ^ rom_data_i;
	assign flow        = (state == ST_RUN);
	assign walk_last   = (rom_addr_o == (`ROM_WORDS - 1));

	always @* begin
		next_state = state;
		case (state)
			ST_CHECK: begin
				if (walk_last) begin
					next_state = (next_digest == rom_expected_i) ? ST_RUN : ST_FAIL;
				end
			end
			ST_RUN:  next_state = ST_RUN;
			ST_FAIL: next_state = ST_FAIL; // only a fresh reset leaves this
			default: next_state = ST_FAIL;
		endcase
	end

	// reset is the power-up; it always reruns the
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			state <= ST_CHECK;
		end else begin
			state <= next_state;
		end
	end

	always @(posedge core_clk_i) begin
		if (srst_i) begin
			rom_addr_o <= 8'h00;
			digest     <= `DIGEST_RESET;
		end else if (state == ST_CHECK) begin
			rom_addr_o <= rom_addr_o + 8'h01;
			digest     <= next_digest;
		end
	end

	// divider held in reset outside failure, so the first blink is a full period
	always @(posedge core_clk_i) begin
		if (srst_i || state != ST_FAIL) begin
			blink_cnt  <= 24'h000000;
			blink_tick <= 1'b0;
		end else if (blink_cnt == (`BLINK_CYCLES - 1)) begin
			blink_cnt  <= 24'h000000;
			blink_tick <= 1'b1;
		end else begin
			blink_cnt  <= blink_cnt + 24'h000001;
			blink_tick <= 1'b0;
		end
	end

	always @(posedge core_clk_i) begin
		if (srst_i || state != ST_FAIL) begin
			fail_led_o <= 1'b0;
		end else if (blink_tick) begin
			fail_led_o <= ~fail_led_o;
		end
	end

	assign port_attach = {ptr_attach_i, key_attach_i};
	assign port_enum   = {ptr_enum_i, key_enum_i};
	assign port_class  = {ptr_class_i, key_class_i};
	assign port_valid  = {ptr_valid_i, key_valid_i};

	// filtering: class check at enumeration, sticky reject until detach
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_port
			assign port_hid[gi] = (port_class[gi*8 +: 8] == `HID_CLASS_CODE);
			always @(posedge core_clk_i) begin
				if (srst_i || !port_attach[gi]) begin
					port_ok[gi]  <= 1'b0;
					port_rej[gi] <= 1'b0; // cleared only by unplug or reset
				end else if (port_enum[gi]) begin
					if (port_hid[gi] && !port_rej[gi] && !port_ok[gi]) begin
						port_ok[gi] <= 1'b1;
					end else if (!port_hid[gi] || port_ok[gi]) begin
						port_ok[gi]  <= 1'b0; // re-enumeration rejects
						port_rej[gi] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// merge: source tag in bit 8; when both arrive, turn alternates which one is taken and the other is dropped
	// a word offered while the fifo is full is dropped, not stalled:
	// the peripherals cannot be held off over usb
	assign key_push       = flow & port_ok[CH_KEY] & port_valid[CH_KEY];
	assign ptr_push       = flow & port_ok[CH_PTR] & port_valid[CH_PTR];
	assign take           = key_push & (~ptr_push | ~turn);
	assign hist_shift     = take & fifo_in_ready;
	assign fifo_in_valid  = key_push | ptr_push;
	assign fifo_in_data   = take ? {`SRC_KEY, key_code_i} : {`SRC_PTR, ptr_data_i};
	assign fifo_out_ready = ~diode_valid_o | diode_ready_i;

	always @(posedge core_clk_i) begin
		if (srst_i) begin
			turn <= 1'b0;
		end else if (key_push && ptr_push && fifo_in_ready) begin
			turn <= ~turn;
		end
	end

	stream_fifo #(
		.WIDTH (`WORD_W),
		.DEPTH (`FIFO_DEPTH),
		.AW    (`FIFO_AW)
	) u_fifo (
		.core_clk_i  (core_clk_i),
		.srst_i      (srst_i),
		.in_valid_i  (fifo_in_valid),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (fifo_in_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_out_ready),
		.out_data_o  (fifo_out_data)
	);

	// output register; nothing returns on this path
	always @(posedge core_clk_i) begin
		if (srst_i || !flow) begin
			diode_valid_o <= 1'b0;
			diode_data_o  <= 9'h000;
		end else if (!diode_valid_o || diode_ready_i) begin
			diode_valid_o <= fifo_out_valid;
			diode_data_o  <= fifo_out_data;
		end
	end

	// last four key codes, volatile, cleared at reset
	generate
		for (gi = 0; gi < `KEY_HIST; gi = gi + 1) begin : g_hist
			if (gi == 0) begin : g_head
				always @(posedge core_clk_i) begin
					if (srst_i) begin
						hist[gi] <= 8'h00;
					end else if (hist_shift) begin
						hist[gi] <= key_code_i;
					end
				end
			end else begin : g_tail
				always @(posedge core_clk_i) begin
					if (srst_i) begin
						hist[gi] <= 8'h00;
					end else if (hist_shift) begin
						hist[gi] <= hist[gi - 1];
					end
				end
			end
		end
	endgenerate

	// rom is reached only by the check walker, no port reads it
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			reject_led_o  <= 1'b0;
			flow_enable_o <= 1'b0;
		end else begin
			reject_led_o  <= (|port_rej) | (unused_lock & 1'b0);
			flow_enable_o <= (next_state == ST_RUN);
		end
	end

	always @(posedge core_clk_i) begin
		if (srst_i) begin
			key_history_o <= 32'h00000000;
		end else begin
			key_history_o <= {hist[3], hist[2], hist[1], hist[0]};
		end
	end
endmodule // hid_filter_gate_control
